//--- freq_prot_pkg.sv
// constants for the frequency protection unit
// assumes one 125 MHz clock and a 32-bit AHB-Lite register port
package freq_prot_pkg;
  // clock and time base
  localparam int CLK_HZ = 125_000_000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
  localparam int NFUNC = 3;
  localparam int FUNC_OVER = 0;
  localparam int FUNC_UNDER = 1;
  localparam int FUNC_SLOPE = 2;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] THR_OFS = 8'h04;
  localparam logic [7:0] DLY_OFS = 8'h10;
  localparam logic [7:0] REG_STRIDE = 8'h04;
  localparam logic [7:0] STATE_OFS = 8'h1c;
  localparam logic [7:0] EVENT_OFS = 8'h20;
  localparam logic [7:0] MASK_OFS = 8'h24;
  // frequency thresholds in 0.1 Hz, slope threshold in 0.1 Hz/s
  localparam logic [9:0] OVER_A_LO = 10'h1f4;
  localparam logic [9:0] OVER_A_HI = 10'h212;
  localparam logic [9:0] OVER_B_LO = 10'h258;
  localparam logic [9:0] OVER_B_HI = 10'h276;
  localparam logic [9:0] UNDER_A_LO = 10'h1c2;
  localparam logic [9:0] UNDER_A_HI = 10'h1f4;
  localparam logic [9:0] UNDER_B_LO = 10'h226;
  localparam logic [9:0] UNDER_B_HI = 10'h258;
  localparam logic [9:0] SLOPE_LO = 10'h001;
  localparam logic [9:0] SLOPE_HI = 10'h064;
  // delays in 10 ms ticks: 100 ms to 300 s
  localparam logic [14:0] DLY_LO = 15'h000a;
  localparam logic [14:0] DLY_HI = 15'h7530;
  // measured values: frequency 0.01 Hz, slope 0.01 Hz/s, voltage permille
  localparam logic [15:0] THR_SCALE = 16'h000a;
  localparam logic [15:0] HYST = 16'h0014;
  localparam logic [15:0] VOLT_GATE = 16'h00c8;
  // reset values
  localparam logic [9:0] OVER_THR_RST = 10'h1fe;
  localparam logic [9:0] UNDER_THR_RST = 10'h1ea;
  localparam logic [9:0] SLOPE_THR_RST = 10'h00a;
  localparam logic [14:0] DLY_RST = 15'h000a;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [5:0] MASK_RST = 6'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

//--- frequency_protection.sv
// frequency protection: over, under and slope functions with timers
// assumes measured values are synchronous to core_clk and an
// AHB-Lite master that puts IDLE after every address phase
//
// Functional notes
// [RULE_01] three inputs: over pick-up on freq above, voltage over 20%
// [RULE_02] single-transformer: over uses line channel, voltage over 20%
// [RULE_03] three inputs: under pick-up when freq below, voltage over 20%
// [RULE_04] single-transformer: under uses line frequency and voltage gate
// [RULE_05] over threshold within 50-53 or 60-63 Hz, 0.1 Hz steps
// [RULE_06] under threshold within 45-50 or 55-60 Hz, 0.1 Hz steps
// [RULE_07] over and under drop out 0.2 Hz past the pick-up point
// [RULE_08] definite delay from overrun, 100 ms to 300 s in 10 ms steps
// [RULE_09] slope pick-up above threshold, 0.1 to 10 Hz/s in 0.1 steps
// [RULE_10] slope function held inhibited in single-transformer mode
// [RULE_11] trip only after pick-up held for the delay; drop clears all
//
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module frequency_protection
  import freq_prot_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [15:0] pos_seq_frequency,
  input wire logic [15:0] pos_seq_voltage,
  input wire logic [15:0] single_line_frequency,
  input wire logic [15:0] single_line_voltage,
  input wire logic signed [15:0] frequency_slope,
  input wire logic single_transformer,
  output logic [2:0] pickup,
  output logic [2:0] trip,
  output logic irq
);

  // register state
  logic [2:0] ctrl_q;
  logic [9:0] thr_q [NFUNC];
  logic [14:0] dly_q [NFUNC];
  logic [5:0] event_q;
  logic [5:0] mask_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] tick_cnt_q;
  logic tick_q;
  logic [14:0] cnt_q [NFUNC];

  // bus decode
  wire logic take = hsel & hready & htrans[1];
  wire logic rd_take = take & ~hwrite;
  wire logic [7:0] a_ofs = haddr[7:0];
  wire logic unused_ok = |hsize | |haddr[31:8];
  wire logic ev_read = rd_take & (a_ofs == EVENT_OFS) & ~unused_ok | 
    rd_take & (a_ofs == EVENT_OFS) & unused_ok;

  // measurement selection
  wire logic [15:0] f_sel = single_transformer ? single_line_frequency
                                               : pos_seq_frequency;
  wire logic [15:0] v_sel = single_transformer ? single_line_voltage
                                               : pos_seq_voltage;
  wire logic v_ok = v_sel > VOLT_GATE; // RULE_01 RULE_02
  wire logic [15:0] slope_abs = frequency_slope[15]
    ? 16'(-frequency_slope) : 16'(frequency_slope);
  wire logic [15:0] over_lim = 16'(thr_q[FUNC_OVER]) * THR_SCALE;
  wire logic [15:0] under_lim = 16'(thr_q[FUNC_UNDER]) * THR_SCALE;
  wire logic [15:0] slope_lim = 16'(thr_q[FUNC_SLOPE]) * THR_SCALE;

  // pick-up with hysteresis on over and under
  wire logic over_rise = f_sel > over_lim; // RULE_01 RULE_02
  wire logic over_hold = f_sel > (over_lim - HYST); // RULE_07
  wire logic under_rise = f_sel < under_lim; // RULE_03 RULE_04
  wire logic under_hold = f_sel < (under_lim + HYST); // RULE_07
  wire logic [2:0] pick_d;
  assign pick_d[FUNC_OVER] = ctrl_q[FUNC_OVER] & v_ok &
    (pickup[FUNC_OVER] ? over_hold : over_rise); // RULE_01 RULE_02
  assign pick_d[FUNC_UNDER] = ctrl_q[FUNC_UNDER] & v_ok &
    (pickup[FUNC_UNDER] ? under_hold : under_rise); // RULE_03 RULE_04
  assign pick_d[FUNC_SLOPE] = ctrl_q[FUNC_SLOPE] & ~single_transformer &
    (slope_abs > slope_lim); // RULE_09 RULE_10

  // write data acceptance windows
  wire logic [9:0] wthr = hwdata[9:0];
  wire logic [14:0] wdly = hwdata[14:0];
  wire logic [2:0] thr_ok;
  assign thr_ok[FUNC_OVER] = ~|hwdata[31:10] &
    ((wthr >= OVER_A_LO && wthr <= OVER_A_HI) ||
     (wthr >= OVER_B_LO && wthr <= OVER_B_HI)); // RULE_05
  assign thr_ok[FUNC_UNDER] = ~|hwdata[31:10] &
    ((wthr >= UNDER_A_LO && wthr <= UNDER_A_HI) ||
     (wthr >= UNDER_B_LO && wthr <= UNDER_B_HI)); // RULE_06
  assign thr_ok[FUNC_SLOPE] = ~|hwdata[31:10] &
    (wthr >= SLOPE_LO && wthr <= SLOPE_HI); // RULE_09
  wire logic dly_ok = ~|hwdata[31:15] &
    (wdly >= DLY_LO && wdly <= DLY_HI); // RULE_08

  // per function timer and events
  logic [2:0] trip_d;
  logic [5:0] ev_set;
  logic [31:0] thr_rd [NFUNC];
  logic [31:0] dly_rd [NFUNC];
  logic [2:0] thr_hit;
  logic [2:0] dly_hit;
  genvar gi;
  generate
    for (gi = 0; gi < NFUNC; gi++)
    begin : g_func
      wire logic [7:0] thr_a = 8'(THR_OFS + REG_STRIDE * 8'(gi));
      wire logic [7:0] dly_a = 8'(DLY_OFS + REG_STRIDE * 8'(gi));
      wire logic wr_thr = wr_pend_q & (wr_addr_q == thr_a) & thr_ok[gi];
      wire logic wr_dly = wr_pend_q & (wr_addr_q == dly_a) & dly_ok;
      assign thr_hit[gi] = a_ofs == thr_a;
      assign dly_hit[gi] = a_ofs == dly_a;
      assign thr_rd[gi] = {22'h00_0000, thr_q[gi]};
      assign dly_rd[gi] = {17'h0_0000, dly_q[gi]};
      assign trip_d[gi] = pick_d[gi] & pickup[gi] &
        (cnt_q[gi] >= dly_q[gi]); // RULE_08 RULE_11
      assign ev_set[gi] = pick_d[gi] & ~pickup[gi];
      assign ev_set[gi + NFUNC] = trip_d[gi] & ~trip[gi];
      always_ff @(posedge core_clk)
      begin
        if (srst)
        begin
          cnt_q[gi] <= 15'h0000;
          thr_q[gi] <= gi == FUNC_OVER ? OVER_THR_RST
                     : gi == FUNC_UNDER ? UNDER_THR_RST : SLOPE_THR_RST;
          dly_q[gi] <= DLY_RST;
        end
        else
        begin
          if (!pickup[gi] || !pick_d[gi])
            cnt_q[gi] <= 15'h0000; // RULE_11
          else if (tick_q && cnt_q[gi] < dly_q[gi])
            cnt_q[gi] <= cnt_q[gi] + 15'h0001; // RULE_08
          if (wr_thr)
            thr_q[gi] <= wthr; // RULE_05 RULE_06 RULE_09
          if (wr_dly)
            dly_q[gi] <= wdly; // RULE_08
        end
      end
    end
  endgenerate

  // read mux
  wire logic [31:0] rd_data =
    (a_ofs == CTRL_OFS) ? {29'h0000_0000, ctrl_q} :
    thr_hit[0] ? thr_rd[0] : thr_hit[1] ? thr_rd[1] :
    thr_hit[2] ? thr_rd[2] : dly_hit[0] ? dly_rd[0] :
    dly_hit[1] ? dly_rd[1] : dly_hit[2] ? dly_rd[2] :
    (a_ofs == STATE_OFS) ? {26'h000_0000, trip, pickup} :
    (a_ofs == EVENT_OFS) ? {26'h000_0000, event_q} :
    (a_ofs == MASK_OFS) ? {26'h000_0000, mask_q} : 32'h0000_0000;
  // set wins over read clear
  wire logic [5:0] event_d = (ev_read ? 6'h00 : event_q) | ev_set;
  wire logic wr_ctrl = wr_pend_q & (wr_addr_q == CTRL_OFS);
  wire logic wr_mask = wr_pend_q & (wr_addr_q == MASK_OFS);
  wire logic tick_end = tick_cnt_q == 32'(TICK_CYCLES - 1);

  // 10 ms time base
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_cnt_q <= tick_end ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
      tick_q <= tick_end;
    end
  end

  // bus slave and outputs
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ctrl_q <= CTRL_RST;
      mask_q <= MASK_RST;
      event_q <= 6'h00;
      pickup <= 3'h0;
      trip <= 3'h0;
      irq <= 1'b0;
    end
    else
    begin
      wr_pend_q <= take & hwrite;
      wr_addr_q <= a_ofs;
      if (rd_take)
        hrdata <= rd_data;
      if (wr_ctrl)
        ctrl_q <= hwdata[2:0];
      if (wr_mask)
        mask_q <= hwdata[5:0];
      event_q <= event_d;
      pickup <= pick_d;
      trip <= trip_d; // RULE_11
      irq <= |(event_d & mask_q);
    end
  end

  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  sequence over_cond_s;
    ctrl_q[FUNC_OVER] && !single_transformer &&
      pos_seq_voltage > VOLT_GATE && pos_seq_frequency > over_lim;
  endsequence
  sequence single_over_s;
    ctrl_q[FUNC_OVER] && single_transformer &&
      single_line_voltage > VOLT_GATE && single_line_frequency > over_lim;
  endsequence

  over_pick_a: assert property (over_cond_s |=> pickup[FUNC_OVER]) // RULE_01
    else $error("over pick-up missing");
  single_over_a: assert property ( // RULE_02
    single_over_s |=> pickup[FUNC_OVER])
    else $error("single channel over pick-up missing");
  under_pick_a: assert property ( // RULE_03
    ctrl_q[FUNC_UNDER] && !single_transformer &&
    pos_seq_voltage > VOLT_GATE && pos_seq_frequency < under_lim
    |=> pickup[FUNC_UNDER]) else $error("under pick-up missing");
  under_gate_a: assert property ( // RULE_04
    single_transformer && single_line_voltage <= VOLT_GATE
    |=> !pickup[FUNC_UNDER] && !pickup[FUNC_OVER])
    else $error("pick-up without voltage");
  over_band_a: assert property ( // RULE_05
    (thr_q[FUNC_OVER] >= OVER_A_LO && thr_q[FUNC_OVER] <= OVER_A_HI) ||
    (thr_q[FUNC_OVER] >= OVER_B_LO && thr_q[FUNC_OVER] <= OVER_B_HI))
    else $error("over threshold out of band");
  under_band_a: assert property ( // RULE_06
    (thr_q[FUNC_UNDER] >= UNDER_A_LO && thr_q[FUNC_UNDER] <= UNDER_A_HI) ||
    (thr_q[FUNC_UNDER] >= UNDER_B_LO && thr_q[FUNC_UNDER] <= UNDER_B_HI))
    else $error("under threshold out of band");
  over_hyst_a: assert property ( // RULE_07
    pickup[FUNC_OVER] && ctrl_q[FUNC_OVER] && v_ok &&
    f_sel > over_lim - HYST |=> pickup[FUNC_OVER])
    else $error("over dropped inside hysteresis");
  trip_delay_a: assert property ( // RULE_08
    $rose(trip[FUNC_OVER]) |-> $past(pickup[FUNC_OVER], 2) &&
    cnt_q[FUNC_OVER] >= dly_q[FUNC_OVER])
    else $error("over trip before delay");
  slope_pick_a: assert property ( // RULE_09
    ctrl_q[FUNC_SLOPE] && !single_transformer && slope_abs > slope_lim
    |=> pickup[FUNC_SLOPE]) else $error("slope pick-up missing");
  slope_inhibit_a: assert property ( // RULE_10
    single_transformer |=> !pickup[FUNC_SLOPE] && !trip[FUNC_SLOPE])
    else $error("slope active in single-transformer mode");
  trip_clear_a: assert property ( // RULE_11
    !pickup[FUNC_UNDER] |-> !trip[FUNC_UNDER] ##1
    (!pickup[FUNC_UNDER] || cnt_q[FUNC_UNDER] <= 15'h0001))
    else $error("under trip or timer survives drop-out");
endmodule

//--- freq_source_model.sv
// upstream measurement model: frequency, voltage, slope and mode
// assumes the bench calls apply() and values change after a clock edge
`timescale 1ns/1ps
module freq_source_model
(
  input wire logic core_clk,
  output logic [15:0] pos_seq_frequency,
  output logic [15:0] pos_seq_voltage,
  output logic [15:0] single_line_frequency,
  output logic [15:0] single_line_voltage,
  output logic signed [15:0] frequency_slope,
  output logic single_transformer
);
  // nominal network at start: 50 Hz, full voltage, three inputs
  initial
  begin
    pos_seq_frequency = 16'h1388;
    pos_seq_voltage = 16'h03e8;
    single_line_frequency = 16'h1388;
    single_line_voltage = 16'h03e8;
    frequency_slope = 16'h0000;
    single_transformer = 1'b0;
  end

  // new measurement set, launched just after a rising edge
  task automatic apply(input logic [15:0] fp, vp, fl, vl, sl,
                       input logic st);
    @(posedge core_clk);
    pos_seq_frequency <= fp;
    pos_seq_voltage <= vp;
    single_line_frequency <= fl;
    single_line_voltage <= vl;
    frequency_slope <= sl;
    single_transformer <= st;
  endtask
endmodule

//--- tb_frequency_protection.sv
// bench for the frequency protection unit
// assumes one 125 MHz clock and a single AHB-Lite slave on the bus
`timescale 1ns/1ps
module tb_frequency_protection;
  import freq_prot_pkg::*;
  localparam int TICKS = 4;
  localparam int LO = 9 * TICKS + 1;
  localparam int HI = 10 * TICKS + 4;
  localparam logic [15:0] NF = 16'h1388;
  localparam logic [15:0] NV = 16'h03e8;
  localparam logic [7:0] RA [11] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10,
    8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h30};
  localparam logic [15:0] RV [11] = '{16'h0000, 16'h01fe, 16'h01ea,
    16'h000a, 16'h000a, 16'h000a, 16'h000a, 16'h0000, 16'h0000, 16'h0000,
    16'h0000};
  localparam logic [7:0] WA [14] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h08,
    8'h08, 8'h08, 8'h0c, 8'h0c, 8'h0c, 8'h10, 8'h10, 8'h10, 8'h10};
  localparam logic [15:0] WD [14] = '{16'h01f3, 16'h0213, 16'h0276,
    16'h01fe, 16'h01f5, 16'h0226, 16'h01ea, 16'h0065, 16'h0064, 16'h000a,
    16'h0009, 16'h7531, 16'h7530, 16'h000a};
  localparam logic [15:0] WE [14] = '{16'h01fe, 16'h01fe, 16'h0276,
    16'h01fe, 16'h01ea, 16'h0226, 16'h01ea, 16'h000a, 16'h0064, 16'h000a,
    16'h000a, 16'h000a, 16'h7530, 16'h000a};
  logic core_clk, srst, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rdata;
  logic [1:0] htrans;
  logic [2:0] hsize, pickup, trip;
  logic [15:0] pos_seq_frequency, pos_seq_voltage;
  logic [15:0] single_line_frequency, single_line_voltage;
  logic signed [15:0] frequency_slope;
  logic single_transformer;
  int n_mismatch, n_compared, n;

  frequency_protection #(.TICK_CYCLES(TICKS)) u_frequency_protection (
    .core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pos_seq_frequency(pos_seq_frequency),
    .pos_seq_voltage(pos_seq_voltage),
    .single_line_frequency(single_line_frequency),
    .single_line_voltage(single_line_voltage),
    .frequency_slope(frequency_slope),
    .single_transformer(single_transformer), .pickup(pickup),
    .trip(trip), .irq(irq));

  freq_source_model u_freq_source_model (
    .core_clk(core_clk), .pos_seq_frequency(pos_seq_frequency),
    .pos_seq_voltage(pos_seq_voltage),
    .single_line_frequency(single_line_frequency),
    .single_line_voltage(single_line_voltage),
    .frequency_slope(frequency_slope),
    .single_transformer(single_transformer));

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic end_sim();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic limit(input int cnt, input int bound);
    if (cnt >= bound)
    begin
      n_mismatch++;
      $display("ERROR %0t: wait limit reached", $time);
      end_sim();
    end
  endtask

  // wait for hready sampled high at a rising edge
  task automatic rdy();
    int k;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 64);
    limit(k, 64);
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    rdy();
    rdata = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rdata, exp);
    chk({30'h0, hresp, hreadyout}, 32'h1);
  endtask

  task automatic step(input logic [15:0] fp, vp, fl, vl, sl,
                      input logic st, input logic [2:0] exp);
    u_freq_source_model.apply(fp, vp, fl, vl, sl, st);
    repeat (3) @(posedge core_clk);
    #1 chk({29'h0, pickup}, {29'h0, exp});
  endtask

  task automatic trip_time(input int f, output int cnt);
    cnt = 0;
    while (trip[f] !== 1'b1 && cnt < 200)
    begin
      @(posedge core_clk);
      #1;
      cnt++;
    end
    limit(cnt, 200);
  endtask

  initial
  begin
    srst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    n_mismatch = 0;
    n_compared = 0;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    for (int i = 0; i < 11; i++)
      rd_chk(RA[i], {16'h0, RV[i]});
    for (int i = 0; i < 14; i++)
    begin
      bus(1'b1, WA[i], {16'h0, WD[i]});
      rd_chk(WA[i], {16'h0, WE[i]});
    end
    bus(1'b1, 8'h00, 32'h0000_0007);
    // over trip with mask clear, then event read and clear
    u_freq_source_model.apply(16'h13f6, 16'h01f4, NF, NV, 16'h0, 1'b0);
    trip_time(0, n);
    chk({31'h0, n >= LO && n <= HI}, 32'h1);
    #1 chk({31'h0, irq}, 32'h0);
    rd_chk(8'h1c, 32'h0000_0009);
    rd_chk(8'h20, 32'h0000_0009);
    rd_chk(8'h20, 32'h0000_0000);
    bus(1'b1, 8'h24, 32'h0000_003f);
    step(16'h13d8, 16'h01f4, NF, NV, 16'h0, 1'b0, 3'h0);
    chk({29'h0, trip}, 32'h0);
    // pick-up lost mid-delay restarts the full delay
    u_freq_source_model.apply(16'h13f6, 16'h01f4, NF, NV, 16'h0, 1'b0);
    repeat (20) @(posedge core_clk);
    u_freq_source_model.apply(16'h13f6, 16'h00c8, NF, NV, 16'h0, 1'b0);
    u_freq_source_model.apply(16'h13f6, 16'h01f4, NF, NV, 16'h0, 1'b0);
    trip_time(0, n);
    chk({31'h0, n >= LO && n <= HI}, 32'h1);
    #1 chk({31'h0, irq}, 32'h1);
    rd_chk(8'h20, 32'h0000_0009);
    repeat (2) @(posedge core_clk);
    #1 chk({31'h0, irq}, 32'h0);
    step(16'h13d8, 16'h01f4, NF, NV, 16'h0, 1'b0, 3'h0);
    step(16'h13f6, 16'h01f4, NF, NV, 16'h0, 1'b0, 3'h1);
    step(16'h13e2, 16'h01f4, NF, NV, 16'h0, 1'b0, 3'h1);
    step(16'h13d8, 16'h01f4, NF, NV, 16'h0, 1'b0, 3'h0);
    step(16'h13f6, 16'h00c8, NF, NV, 16'h0, 1'b0, 3'h0);
    step(NF, NV, 16'h13f6, 16'h01f4, 16'h0, 1'b1, 3'h1);
    step(16'h13f6, NV, NF, NV, 16'h0, 1'b1, 3'h0);
    step(NF, NV, 16'h131a, 16'h01f4, 16'h0, 1'b1, 3'h2);
    step(NF, NV, 16'h131a, 16'h00c8, 16'h0, 1'b1, 3'h0);
    step(16'h131a, NV, NF, NV, 16'h0, 1'b0, 3'h2);
    step(16'h132e, NV, NF, NV, 16'h0, 1'b0, 3'h2);
    step(16'h1338, NV, NF, NV, 16'h0, 1'b0, 3'h0);
    step(NF, NV, NF, NV, 16'hff6a, 1'b1, 3'h0);
    step(NF, NV, NF, NV, 16'hff6a, 1'b0, 3'h4);
    step(NF, NV, NF, NV, 16'h0064, 1'b0, 3'h0);
    // under and slope trips, then slope cleared by single mode
    u_freq_source_model.apply(16'h131a, NV, NF, NV, 16'h0, 1'b0);
    trip_time(1, n);
    chk({31'h0, n >= LO && n <= HI}, 32'h1);
    u_freq_source_model.apply(NF, NV, NF, NV, 16'hff6a, 1'b0);
    trip_time(2, n);
    chk({31'h0, n >= LO && n <= HI}, 32'h1);
    step(NF, NV, NF, NV, 16'hff6a, 1'b1, 3'h0);
    chk({29'h0, trip}, 32'h0);
    end_sim();
  end
endmodule
